//--- rcc_device.sv
// Purpose: Reset sequencing, reset cause, memory gating and clock configuration
// Assumes: rx arrives asynchronously; memory self-test result comes from the memory
// Notes: Serial interface is held idle and reset while the unit is in reset
// Functional notes
// - Long receive-line low forces reset
// - Leave reset 900us after line release
// - Line-hold reset loads cause 011
// - Keyed soft-reset write resets, back within 650us
// - Soft reset loads cause 100; reserved never
// - Memory access blocked during reset
// - Self-test on exit; memory only if passing
// - Line reset grants memory 30.9ms later
// - Serial interface idle in reset, runs after
// - Host performs line-hold reset after power-on; rcc_host does it only on an APB command
// - Fast oscillator re-enabled by any reset
// - Slow oscillator always runs
// - Sampler rate select chooses four rates
// - Software keeps sampler at quarter/eighth rate
// - Metering clock select: fast or quarter
// - Oscillator trim steps two percent
// - Sixty-hertz boost multiplies by 1.2
// - Resets also reset serial interface
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ns
module rcc_device import rcc_pkg::*; #(
	parameter int LOW_TICKS = LINE_LOW_TICKS,
	parameter int SLOW_DIV_CYC = SLOW_DIV,
	parameter int LINE_EXIT = LINE_EXIT_CYC,
	parameter int SOFT_EXIT = SOFT_EXIT_CYC,
	parameter int TEST_CYC = SELFTEST_CYC,
	parameter int GRANT = GRANT_CYC
) (
	input wire logic clk_sys_i, // System clock
	input wire logic reset_n_i, // Power-on reset, active low
	rcc_link_if.dev link, // Host link
	input wire logic selftest_err_i, // Memory self-test error seen
	output logic in_reset_o, // Unit in reset state
	output logic uart_hold_o, // Serial interface held idle and reset
	output logic mem_access_ok_o, // Memory may be accessed
	output logic selftest_run_o, // Memory self-test running
	output logic fast_osc_en_o, // Fast oscillator enable
	output logic slow_osc_en_o, // Slow oscillator enable
	output logic [1:0] sampler_rate_select_o, // Sampler rate code
	output logic [5:0] sampler_div_o, // Fast clock divide for sampler clock
	output logic metering_clock_select_o, // Metering clock code
	output logic [2:0] metering_div_o, // Fast clock divide for metering clock
	output logic [4:0] osc_trim_o, // Oscillator trim code
	output logic signed [6:0] osc_trim_pct_o, // Trim in percent
	output logic osc_boost_sixty_hz_o // Frequency times 1.2
);
	localparam rcc_cnt_t L_EXIT_END = rcc_cnt_t'(LINE_EXIT - 1);
	localparam rcc_cnt_t S_EXIT_END = rcc_cnt_t'(SOFT_EXIT - 1);
	localparam rcc_cnt_t L_TEST_END = rcc_cnt_t'(LINE_EXIT + TEST_CYC - 1);
	localparam rcc_cnt_t S_TEST_END = rcc_cnt_t'(SOFT_EXIT + TEST_CYC - 1);
	localparam rcc_cnt_t GRANT_END = rcc_cnt_t'(GRANT - 1);
	localparam logic [SDIV_W-1:0] DIV_END = SDIV_W'(SLOW_DIV_CYC - 1);
	localparam logic [LOW_W-1:0] LOW_END = LOW_W'(LOW_TICKS);

	function automatic logic signed [6:0] trim_pct(input logic [4:0] c);
		logic signed [6:0] r;
		r = 7'sh00;
		if (!c[4]) begin
			r = -$signed({1'b0, c, 1'b0});
		end else begin
			r = $signed({1'b0, 5'(~c + 5'h01), 1'b0});
		end
		return r;
	endfunction

	rcc_dev_state_e state_reg;
	rcc_cnt_t cnt_reg;
	logic [2:0] cause_reg;
	logic grant_reg;
	logic fail_reg;
	logic [31:0] ctrl_reg;
	logic [SDIV_W-1:0] div_reg;
	logic slow_tick;
	logic rx_s1, rx_s2, rx_s3, rx_lvl_reg;
	logic [LOW_W-1:0] low_reg;
	logic line_trip;
	logic ack_reg;
	logic [31:0] rdata_reg;
	logic acc;
	logic key_hit;
	logic enter_reset;
	logic soft_cause;
	logic in_reset;
	rcc_cnt_t exit_end;
	rcc_cnt_t test_end;
	logic [31:0] status_word;

	// Slow oscillator tick; only the power-on reset stops it
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			div_reg <= '0;
		end else if (div_reg == DIV_END) begin
			div_reg <= '0;
		end else begin
			div_reg <= div_reg + 1'b1;
		end
	end
	assign slow_tick = (div_reg == DIV_END);
	assign slow_osc_en_o = 1'b1;

	// Receive line synchroniser, change taken when stages two and three agree
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rx_s1 <= 1'b1;
			rx_s2 <= 1'b1;
			rx_s3 <= 1'b1;
			rx_lvl_reg <= 1'b1;
		end else begin
			rx_s1 <= link.rx;
			rx_s2 <= rx_s1;
			rx_s3 <= rx_s2;
			if (rx_s2 == rx_s3) begin
				rx_lvl_reg <= rx_s3;
			end
		end
	end

	// Low-time measurement in slow ticks; a short pulse restarts it
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			low_reg <= '0;
		end else if (rx_lvl_reg) begin
			low_reg <= '0;
		end else if (slow_tick && low_reg != LOW_END) begin
			low_reg <= low_reg + 1'b1;
		end
	end
	assign line_trip = (low_reg == LOW_END);

	assign in_reset = (state_reg == DS_HOLD) || (state_reg == DS_EXIT);
	assign acc = (link.req_wr || link.req_rd) && !ack_reg && !in_reset;
	assign key_hit = acc && link.req_wr && link.req_addr == REG_SOFT && link.req_wdata == SOFT_KEY;
	assign enter_reset = (line_trip && state_reg != DS_HOLD) || key_hit;
	assign soft_cause = (cause_reg == CAUSE_SOFT);
	assign exit_end = soft_cause ? S_EXIT_END : L_EXIT_END;
	assign test_end = soft_cause ? S_TEST_END : L_TEST_END;

	// Reset sequence, cause and memory grant
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_reg <= DS_RUN;
			cnt_reg <= '0;
			cause_reg <= CAUSE_RST;
			grant_reg <= 1'b0;
			fail_reg <= 1'b0;
		end else if (line_trip && state_reg != DS_HOLD) begin
			state_reg <= DS_HOLD;
			cnt_reg <= '0;
			cause_reg <= CAUSE_LINE;
			grant_reg <= 1'b0;
			fail_reg <= 1'b0;
		end else if (key_hit) begin
			state_reg <= DS_EXIT;
			cnt_reg <= '0;
			cause_reg <= CAUSE_SOFT;
			grant_reg <= 1'b0;
			fail_reg <= 1'b0;
		end else begin
			unique case (state_reg)
				DS_RUN: begin
					cnt_reg <= '0;
				end
				DS_HOLD: begin
					cnt_reg <= '0;
					if (rx_lvl_reg) begin
						state_reg <= DS_EXIT;
					end
				end
				DS_EXIT: begin
					cnt_reg <= cnt_reg + 1'b1;
					if (cnt_reg == exit_end) begin
						state_reg <= DS_TEST;
					end
				end
				DS_TEST: begin
					cnt_reg <= cnt_reg + 1'b1;
					if (cnt_reg == test_end) begin
						if (selftest_err_i) begin
							state_reg <= DS_RUN;
							fail_reg <= 1'b1;
						end else if (!soft_cause && cnt_reg < GRANT_END) begin
							state_reg <= DS_WAIT;
						end else begin
							state_reg <= DS_RUN;
							grant_reg <= 1'b1;
						end
					end
				end
				DS_WAIT: begin
					cnt_reg <= cnt_reg + 1'b1;
					if (cnt_reg == GRANT_END) begin
						state_reg <= DS_RUN;
						grant_reg <= 1'b1;
					end
				end
			endcase
		end
	end

	// Control register; any reset event returns it to defaults
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ctrl_reg <= CTRL_RST;
		end else if (enter_reset) begin
			ctrl_reg <= CTRL_RST;
		end else if (acc && link.req_wr && link.req_addr == REG_CTRL) begin
			ctrl_reg <= (ctrl_reg & ~CTRL_WMASK) | (link.req_wdata & CTRL_WMASK);
		end
	end

	always_comb begin
		status_word = 32'h0000_0000;
		status_word[CAUSE_LSB +: 3] = cause_reg;
		status_word[ST_GRANT_BIT] = grant_reg;
		status_word[ST_FAIL_BIT] = fail_reg;
		status_word[ST_TEST_BIT] = (state_reg == DS_TEST);
	end

	// Register answers; no answer while in reset
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ack_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
		end else begin
			ack_reg <= acc;
			if (acc && link.req_rd) begin
				if (link.req_addr == REG_STATUS) begin
					rdata_reg <= status_word;
				end else if (link.req_addr == REG_CTRL) begin
					rdata_reg <= ctrl_reg;
				end else begin
					rdata_reg <= 32'h0000_0000;
				end
			end
		end
	end
	assign link.rsp_ack = ack_reg;
	assign link.rsp_rdata = rdata_reg;

	// Clock configuration decode
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sampler_div_o <= 6'h04;
			metering_div_o <= 3'h1;
			osc_trim_pct_o <= 7'sh00;
		end else begin
			sampler_div_o <= 6'h04 << ctrl_reg[SAMP_LSB +: 2];
			metering_div_o <= ctrl_reg[MCLK_BIT] ? 3'h4 : 3'h1;
			osc_trim_pct_o <= trim_pct(ctrl_reg[TRIM_LSB +: 5]);
		end
	end
	assign sampler_rate_select_o = ctrl_reg[SAMP_LSB +: 2];
	assign metering_clock_select_o = ctrl_reg[MCLK_BIT];
	assign osc_trim_o = ctrl_reg[TRIM_LSB +: 5];
	assign osc_boost_sixty_hz_o = ctrl_reg[BOOST_BIT];
	assign fast_osc_en_o = !ctrl_reg[FOSC_OFF_BIT];
	assign in_reset_o = in_reset;
	assign uart_hold_o = in_reset;
	assign mem_access_ok_o = grant_reg;
	assign selftest_run_o = (state_reg == DS_TEST);
endmodule

//--- rcc_host.sv
// Purpose: Host controller driving the receive line and register requests
// Assumes: Software orders it over APB
// Notes: Commands are ignored while a previous one is busy
`timescale 1ns/1ns
module rcc_host import rcc_pkg::*; #(
	parameter int HOLD = HOST_HOLD_CYC
) (
	input wire logic clk_sys_i, // System clock
	input wire logic reset_n_i, // Reset, active low
	input wire logic psel_i, // APB select
	input wire logic penable_i, // APB enable
	input wire logic pwrite_i, // APB write
	input wire logic [7:0] paddr_i, // APB address
	input wire logic [31:0] pwdata_i, // APB write data
	output logic [31:0] prdata_o, // APB read data
	output logic pready_o, // APB ready
	output logic pslverr_o, // APB error on unmapped address
	rcc_link_if.host link // Device link
);
	localparam logic [HOLD_W-1:0] HOLD_END = HOLD_W'(HOLD - 1);

	rcc_host_state_e state_reg;
	logic [HOLD_W-1:0] hold_reg;
	logic [15:0] addr_reg;
	logic [31:0] wdata_reg;
	logic [31:0] rdata_reg;
	logic [31:0] prdata_reg;
	logic wr_reg;
	logic rd_reg;
	logic rx_reg;
	logic apb_wr;
	logic mapped;

	assign apb_wr = psel_i && penable_i && pwrite_i;
	assign mapped = paddr_i == HREG_CMD || paddr_i == HREG_ADDR || paddr_i == HREG_WDATA
		|| paddr_i == HREG_RDATA || paddr_i == HREG_STAT;
	assign pready_o = psel_i && penable_i;
	assign pslverr_o = psel_i && penable_i && !mapped;
	assign prdata_o = prdata_reg;

	// Read data captured in the setup cycle
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			prdata_reg <= 32'h0000_0000;
		end else if (psel_i && !penable_i) begin
			unique case (paddr_i)
				HREG_ADDR: prdata_reg <= {16'h0000, addr_reg};
				HREG_WDATA: prdata_reg <= wdata_reg;
				HREG_RDATA: prdata_reg <= rdata_reg;
				HREG_STAT: prdata_reg <= {31'h0000_0000, state_reg != HS_IDLE};
				default: prdata_reg <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			addr_reg <= 16'h0000;
			wdata_reg <= 32'h0000_0000;
		end else if (apb_wr && state_reg == HS_IDLE) begin
			if (paddr_i == HREG_ADDR) begin
				addr_reg <= pwdata_i[15:0];
			end
			if (paddr_i == HREG_WDATA) begin
				wdata_reg <= pwdata_i;
			end
		end
	end

	// Command sequencer: line hold or one held register request
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_reg <= HS_IDLE;
			hold_reg <= '0;
			rx_reg <= 1'b1;
			wr_reg <= 1'b0;
			rd_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
		end else begin
			unique case (state_reg)
				HS_IDLE: begin
					hold_reg <= '0;
					if (apb_wr && paddr_i == HREG_CMD) begin
						if (pwdata_i[CMD_LINE_BIT]) begin
							state_reg <= HS_LOW;
							rx_reg <= 1'b0;
						end else if (pwdata_i[CMD_WR_BIT] || pwdata_i[CMD_RD_BIT]) begin
							state_reg <= HS_ACC;
							wr_reg <= pwdata_i[CMD_WR_BIT];
							rd_reg <= !pwdata_i[CMD_WR_BIT];
						end
					end
				end
				HS_LOW: begin
					hold_reg <= hold_reg + 1'b1;
					if (hold_reg == HOLD_END) begin
						state_reg <= HS_IDLE;
						rx_reg <= 1'b1;
					end
				end
				HS_ACC: begin
					if (link.rsp_ack) begin
						state_reg <= HS_IDLE;
						wr_reg <= 1'b0;
						rd_reg <= 1'b0;
						if (rd_reg) begin
							rdata_reg <= link.rsp_rdata;
						end
					end
				end
			endcase
		end
	end

	assign link.rx = rx_reg;
	assign link.req_wr = wr_reg;
	assign link.req_rd = rd_reg;
	assign link.req_addr = addr_reg;
	assign link.req_wdata = wdata_reg;
endmodule

//--- rcc_link_checker.sv
// Purpose: Concurrent checks on the link between host controller and reset unit
// Assumes: Sees only the link signals, clock and reset
// Notes: Instantiated beside the link in the testbench
`timescale 1ns/1ns
module rcc_link_checker (
	input wire logic clk_sys_i, // System clock
	input wire logic reset_n_i, // Reset, active low
	input wire logic rx_i, // Receive line
	input wire logic req_wr_i, // Write request
	input wire logic req_rd_i, // Read request
	input wire logic [15:0] req_addr_i, // Request address
	input wire logic [31:0] req_wdata_i, // Request write data
	input wire logic rsp_ack_i, // Acknowledge
	input wire logic [31:0] rsp_rdata_i // Read data
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!reset_n_i);
	ack_pulse_a: assert property (rsp_ack_i |=> !rsp_ack_i)
		else $error("ack longer than one cycle");
	ack_cause_a: assert property ($rose(rsp_ack_i) |-> $past(req_wr_i || req_rd_i))
		else $error("ack without request");
	ack_bound_a: assert property ((req_wr_i || req_rd_i) && !rsp_ack_i |-> ##[1:300] rsp_ack_i)
		else $error("no ack");
	req_hold_a: assert property (req_wr_i && !rsp_ack_i |=> req_wr_i && $stable(req_addr_i) && $stable(req_wdata_i))
		else $error("write request dropped early");
	req_drop_a: assert property (rsp_ack_i |=> !(req_wr_i || req_rd_i))
		else $error("request kept after ack");
	req_excl_a: assert property (!(req_wr_i && req_rd_i))
		else $error("read and write together");
	rdata_stand_a: assert property ($changed(rsp_rdata_i) |-> rsp_ack_i && $past(req_rd_i))
		else $error("read data moved");
	rx_hold_a: assert property ($fell(rx_i) |=> !rx_i [*8])
		else $error("line low too short");
endmodule

//--- rcc_link_if.sv
// Purpose: Link between host controller and reset and clock control unit
// Assumes: Register requests stand in for decoded serial frames
// Notes: Requests are held until the one-cycle acknowledge
`timescale 1ns/1ns
interface rcc_link_if;
	logic rx;
	logic req_wr;
	logic req_rd;
	logic [15:0] req_addr;
	logic [31:0] req_wdata;
	logic rsp_ack;
	logic [31:0] rsp_rdata;
	modport host (output rx, output req_wr, output req_rd, output req_addr, output req_wdata,
		input rsp_ack, input rsp_rdata);
	modport dev (input rx, input req_wr, input req_rd, input req_addr, input req_wdata,
		output rsp_ack, output rsp_rdata);
endinterface

//--- rcc_pkg.sv
// Purpose: Shared constants and types of the reset and clock control unit and its host
// Assumes: 20 MHz system clock; slow oscillator modelled as an enable tick
// Notes: Cycle counts are derived from the printed times
package rcc_pkg;
	localparam int CLK_HZ = 20_000_000;
	localparam int CLK_KHZ = CLK_HZ / 1000;
	localparam int SLOW_HZ = 32768;
	localparam int T_LINE_LOW_MS = 70;
	localparam int T_LINE_EXIT_US = 900;
	localparam int T_SOFT_EXIT_US = 650;
	localparam int T_SELFTEST_US = 1250;
	localparam int T_GRANT_US = 30900;
	// Least times round up, longest times round down
	localparam int SLOW_DIV = CLK_HZ / SLOW_HZ;
	localparam int LINE_LOW_TICKS = (T_LINE_LOW_MS * SLOW_HZ + 999) / 1000;
	localparam int LINE_EXIT_CYC = (T_LINE_EXIT_US * CLK_KHZ + 999) / 1000;
	localparam int SOFT_EXIT_CYC = (T_SOFT_EXIT_US * CLK_KHZ) / 1000;
	localparam int SELFTEST_CYC = (T_SELFTEST_US * CLK_KHZ + 999) / 1000;
	localparam int GRANT_CYC = (T_GRANT_US * CLK_KHZ + 999) / 1000;
	localparam int HOST_HOLD_CYC = T_LINE_LOW_MS * CLK_KHZ;
	localparam int CNT_W = 20;
	localparam int SDIV_W = 10;
	localparam int LOW_W = 12;
	localparam int HOLD_W = 21;
	typedef logic [CNT_W-1:0] rcc_cnt_t;
	// Device registers
	localparam logic [15:0] REG_STATUS = 16'h00CA;
	localparam logic [15:0] REG_CTRL = 16'h0180;
	localparam logic [15:0] REG_SOFT = 16'h01BF;
	localparam logic [31:0] SOFT_KEY = 32'h4572BEAF;
	localparam int CAUSE_LSB = 3;
	localparam logic [2:0] CAUSE_LINE = 3'h3;
	localparam logic [2:0] CAUSE_SOFT = 3'h4;
	localparam logic [2:0] CAUSE_RST = 3'h3;
	localparam int ST_GRANT_BIT = 0;
	localparam int ST_FAIL_BIT = 1;
	localparam int ST_TEST_BIT = 2;
	localparam int SAMP_LSB = 20;
	localparam int MCLK_BIT = 19;
	localparam int TRIM_LSB = 7;
	localparam int BOOST_BIT = 6;
	localparam int FOSC_OFF_BIT = 0;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] CTRL_WMASK = 32'h0038_0FC1;
	// Host APB registers
	localparam logic [7:0] HREG_CMD = 8'h00;
	localparam logic [7:0] HREG_ADDR = 8'h04;
	localparam logic [7:0] HREG_WDATA = 8'h08;
	localparam logic [7:0] HREG_RDATA = 8'h0C;
	localparam logic [7:0] HREG_STAT = 8'h10;
	localparam int CMD_LINE_BIT = 0;
	localparam int CMD_WR_BIT = 1;
	localparam int CMD_RD_BIT = 2;
	typedef enum logic [2:0] {DS_RUN, DS_HOLD, DS_EXIT, DS_TEST, DS_WAIT} rcc_dev_state_e;
	typedef enum logic [1:0] {HS_IDLE, HS_LOW, HS_ACC} rcc_host_state_e;
endpackage

//--- test_reset_and_clock_control.sv
// Purpose: Self-checking bench for the host controller and reset unit joined by the link
// Assumes: Shortened counts; host ordered over APB
// Notes: Control rows run in a loop, resets are hand-written
`timescale 1ns/1ns
module test_reset_and_clock_control import rcc_pkg::*;;
	typedef struct packed {logic [31:0] ctrl; logic [5:0] sdiv; logic [2:0] mdiv; logic [6:0] pct; logic fen;} rcc_row_s;
	logic clk_sys_i = 0;
	logic reset_n_i, psel, penable, pwrite, pready, pslverr, err_i;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic in_rst, hold, mem_ok, st_run, fen, sen, mcs, boost, e;
	logic [1:0] srs;
	logic [5:0] sdiv;
	logic [2:0] mdiv;
	logic [4:0] trim;
	logic signed [6:0] pct;
	int err_count = 0, checks = 0, n, n1;
	rcc_row_s rows [5] = '{'{32'h8000_0000, 6'h04, 3'h1, 7'h00, 1'b1},
		'{32'h0010_0080, 6'h08, 3'h1, 7'h7E, 1'b1},
		'{32'h0028_0780, 6'h10, 3'h4, 7'h62, 1'b1}, '{32'h0030_0840, 6'h20, 3'h1, 7'h20, 1'b1},
		'{32'h0000_0F81, 6'h04, 3'h1, 7'h02, 1'b0}};
	always #25 clk_sys_i = ~clk_sys_i;
	rcc_link_if rcc_link_if_i ();
	rcc_device #(.LOW_TICKS(8), .SLOW_DIV_CYC(4), .LINE_EXIT(20), .SOFT_EXIT(15), .TEST_CYC(30), .GRANT(100))
		rcc_device_i (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .link(rcc_link_if_i.dev), .selftest_err_i(err_i),
		.in_reset_o(in_rst), .uart_hold_o(hold), .mem_access_ok_o(mem_ok), .selftest_run_o(st_run),
		.fast_osc_en_o(fen), .slow_osc_en_o(sen), .sampler_rate_select_o(srs), .sampler_div_o(sdiv),
		.metering_clock_select_o(mcs), .metering_div_o(mdiv), .osc_trim_o(trim), .osc_trim_pct_o(pct),
		.osc_boost_sixty_hz_o(boost));
	rcc_host #(.HOLD(50)) rcc_host_i (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .link(rcc_link_if_i.host));
	rcc_link_checker rcc_link_checker_i (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .rx_i(rcc_link_if_i.rx),
		.req_wr_i(rcc_link_if_i.req_wr), .req_rd_i(rcc_link_if_i.req_rd), .req_addr_i(rcc_link_if_i.req_addr),
		.req_wdata_i(rcc_link_if_i.req_wdata), .rsp_ack_i(rcc_link_if_i.rsp_ack),
		.rsp_rdata_i(rcc_link_if_i.rsp_rdata));
	task automatic test_done();
		if (err_count == 0 && checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd, output logic er);
		int k;
		@(posedge clk_sys_i);
		psel <= 1;
		penable <= 0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys_i);
		penable <= 1;
		k = 0;
		do begin
			@(posedge clk_sys_i);
			k++;
			if (k > 50) begin
				err_count++;
				test_done();
			end
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic wait_idle();
		int k;
		logic [31:0] s;
		logic er;
		k = 0;
		s = 32'h1;
		while (s[0] !== 1'b0) begin
			apb(0, HREG_STAT, 32'h0, s, er);
			k++;
			if (k > 200) begin
				err_count++;
				test_done();
			end
		end
	endtask
	task automatic host_req(input logic [15:0] a, input logic [31:0] d, input logic [31:0] c);
		logic [31:0] r;
		logic er;
		apb(1, HREG_ADDR, {16'h0, a}, r, er);
		apb(1, HREG_WDATA, d, r, er);
		apb(1, HREG_CMD, c, r, er);
	endtask
	task automatic host_read(input logic [15:0] a, output logic [31:0] rd);
		logic er;
		host_req(a, 32'h0, 32'h4);
		wait_idle();
		apb(0, HREG_RDATA, 32'h0, rd, er);
	endtask
	function automatic logic probe(input int w);
		case (w)
			0: return in_rst;
			1: return mem_ok;
			default: return rcc_link_if_i.rx;
		endcase
	endfunction
	task automatic wait_for(input int w, input logic v, output int cnt);
		cnt = 0;
		while (probe(w) !== v) begin
			@(negedge clk_sys_i);
			cnt++;
			if (cnt > 3000) begin
				err_count++;
				test_done();
			end
		end
	endtask
	initial begin
		reset_n_i <= 1'b0;
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= 1'b0;
		paddr <= 8'h00;
		pwdata <= 32'h0000_0000;
		err_i <= 1'b0;
		repeat (12) @(posedge clk_sys_i);
		reset_n_i <= 1;
		repeat (2) @(negedge clk_sys_i);
		chk(32'({in_rst, mem_ok, sen, fen, sdiv}), 32'h0C4);
		host_read(REG_STATUS, q);
		chk(q, 32'h18);
		apb(0, 8'h20, 32'h0, q, e);
		chk(32'(e), 32'h1);
		foreach (rows[i]) begin
			host_req(REG_CTRL, rows[i].ctrl, 32'h2);
			wait_idle();
			repeat (3) @(negedge clk_sys_i);
			chk(32'(sdiv), 32'(rows[i].sdiv));
			chk(32'(mdiv), 32'(rows[i].mdiv));
			chk(32'(pct), 32'(signed'(rows[i].pct)));
			chk(32'({boost, srs, mcs, trim}), 32'({rows[i].ctrl[6], rows[i].ctrl[21:19], rows[i].ctrl[11:7]}));
			chk(32'(fen), 32'(rows[i].fen));
			host_read(REG_CTRL, q);
			chk(q, rows[i].ctrl & CTRL_WMASK);
		end
		host_req(16'h0, 32'h0, 32'h1);
		wait_for(0, 1'b1, n);
		@(negedge clk_sys_i);
		chk(32'({fen, hold, mem_ok}), 32'h6);
		chk(32'(pct), 32'h0);
		wait_for(2, 1'b1, n);
		wait_for(0, 1'b0, n1);
		chk(32'(n1 >= 20 && n1 <= 26), 32'h1);
		@(negedge clk_sys_i);
		chk(32'({st_run, mem_ok}), 32'h2);
		wait_for(1, 1'b1, n);
		chk(32'(n1 + n >= 98 && n1 + n <= 108), 32'h1);
		host_read(REG_STATUS, q);
		chk(q, 32'h19);
		host_req(REG_SOFT, SOFT_KEY ^ 32'h1, 32'h2);
		wait_idle();
		chk(32'({in_rst, mem_ok}), 32'h1);
		@(posedge clk_sys_i);
		err_i <= 1;
		host_req(REG_SOFT, SOFT_KEY, 32'h2);
		wait_for(0, 1'b1, n);
		@(negedge clk_sys_i);
		chk(32'({hold, mem_ok}), 32'h2);
		wait_for(0, 1'b0, n);
		chk(32'(n >= 12 && n <= 16), 32'h1);
		repeat (60) @(negedge clk_sys_i);
		chk(32'(mem_ok), 32'h0);
		host_req(REG_STATUS, 32'hFFFF_FFFF, 32'h2);
		wait_idle();
		host_read(REG_STATUS, q);
		chk(q, 32'h22);
		test_done();
	end
endmodule
